// >>> rtl/ubd_pkg.sv
// package: constants and types of the uart buffer data path
// ------------------------------------------------------------
// Behaviour
// RQ1: received characters queue in a sixteen-byte store read through the data port.
// RQ2: receive shifter assembles serial input bits into characters and stores them.
// RQ3: non-fifo mode: placed character with receive enable set raises the interrupt.
// RQ4: non-fifo mode: reading the received character clears that interrupt.
// RQ5: fifo mode: interrupts follow the fifo control thresholds instead.
// RQ6: eight-bit scratch byte reads back freely and touches nothing else.
// RQ7: characters to send queue in a sixteen-byte store written through the data port.
// RQ8: next character enters the transmit shifter only when idle, then shifts out.
// RQ9: non-fifo mode: empty holding with enable bit 1 interrupts; a write clears it.
// RQ10: bit timing is the reference clock divided by the programmed divisor.
// RQ11: framing follows the line control settings.
// RQ12: divisors such as 3840, 20, 5 give the matching sixteen-times clock.
// RQ13: baud generator ticks at sixteen times the baud rate for sampling and shifting.
// RQ14: writing the divisor reloads the sixteen-bit baud counter at once.
// RQ15: frame: low start, data lsb first, optional parity, high stop; idles high.
// ------------------------------------------------------------
package ubd_pkg;
   localparam int DW = 32;
   localparam int RAW = 8;
   localparam logic [7:0] OFS_DATA = 8'h00;
   localparam logic [7:0] OFS_IEN = 8'h04;
   localparam logic [7:0] OFS_LCTL = 8'h08;
   localparam logic [7:0] OFS_DIV = 8'h0c;
   localparam logic [7:0] OFS_FCTL = 8'h10;
   localparam logic [7:0] OFS_SCR = 8'h14;
   localparam logic [7:0] OFS_ISTAT = 8'h18;
   localparam logic [7:0] OFS_STATE = 8'h1c;
   localparam int IRQ_RX = 0;
   localparam int IRQ_TX = 1;
   localparam int LC_STOP2 = 2;
   localparam int LC_PEN = 3;
   localparam int LC_EVEN = 4;
   localparam int FC_EN = 0;
   localparam int FC_RXT = 1;
   localparam int FC_TXT = 5;
   localparam int FC_TW = 4;
   localparam int ST_TXC = 8;
   localparam int ST_TXB = 16;
   localparam int ST_RXB = 17;
   localparam int HT_ACT = 1;
   localparam logic [15:0] DIV_RST = 16'h0014;
   localparam logic [15:0] DIV_ONE = 16'h0001;
   localparam logic [4:0] LCTL_RST = 5'h03;
   localparam logic [3:0] TK_MID = 4'h7;
   localparam logic [3:0] TK_END = 4'hf;
   localparam logic [2:0] BIT_MIN = 3'h4;
   localparam logic [2:0] PAD_MAX = 3'h3;
   typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} ubd_ser_t;
endpackage

// >>> rtl/ubd_top.sv
// module: ahb-lite slave, baud generator, serial shifters and fifos of one channel
//
// Added by the designer: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
module ubd_top #(
   parameter int DEPTH = 16
) (
   input wire logic CLK_IN,
   input wire logic ARST_N_IN,
   input wire logic HSEL_IN,
   input wire logic [ubd_pkg::DW-1:0] HADDR_IN,
   input wire logic [1:0] HTRANS_IN,
   input wire logic HWRITE_IN,
   input wire logic [2:0] HSIZE_IN,
   input wire logic [ubd_pkg::DW-1:0] HWDATA_IN,
   input wire logic HREADY_IN,
   output logic [ubd_pkg::DW-1:0] HRDATA_OUT,
   output logic HREADYOUT_OUT,
   output logic HRESP_OUT,
   input wire logic RXD_IN,
   output logic TXD_OUT,
   output logic IRQ_OUT
);
   import ubd_pkg::*;
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("DEPTH must be a power of two of at least 2");
   end

   function automatic logic [2:0] last_bit(input logic [4:0] lc);
      last_bit = BIT_MIN + {1'b0, lc[1:0]};
   endfunction
   function automatic logic [2:0] pad(input logic [4:0] lc);
      pad = PAD_MAX - {1'b0, lc[1:0]};
   endfunction
   // non-fifo mode behaves as a single holding byte
   function automatic logic [CW-1:0] cap(input logic en);
      cap = en ? CW'(DEPTH) : CW'(1);
   endfunction

   // ------------------------------------------------------------
   // pin synchroniser and bus front end
   // ------------------------------------------------------------
   logic rx_meta_ff, rx_sync_ff;
   logic wr_ff, rdy_ff, resp_ff;
   logic [RAW-1:0] wa_ff;
   logic [DW-1:0] rdata_ff, nxt_rdata;
   logic hit, ap_act, ap_rd;
   logic [RAW-1:0] ap_addr;
   logic w_data, w_ien, w_lctl, w_div, w_fctl, w_scr;
   assign ap_addr = HADDR_IN[RAW-1:0];
   assign hit = HADDR_IN[DW-1:RAW] == '0;
   assign ap_act = HSEL_IN && HTRANS_IN[HT_ACT] && HREADY_IN && hit;
   assign ap_rd = ap_act && !HWRITE_IN;
   assign w_data = wr_ff && wa_ff == OFS_DATA;
   assign w_ien = wr_ff && wa_ff == OFS_IEN;
   assign w_lctl = wr_ff && wa_ff == OFS_LCTL;
   assign w_div = wr_ff && wa_ff == OFS_DIV;
   assign w_fctl = wr_ff && wa_ff == OFS_FCTL;
   assign w_scr = wr_ff && wa_ff == OFS_SCR;

   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         rx_meta_ff <= 1'b1;
         rx_sync_ff <= 1'b1;
         wr_ff <= 1'b0;
         wa_ff <= '0;
         rdata_ff <= '0;
         rdy_ff <= 1'b1;
         resp_ff <= 1'b0;
      end else begin
         rx_meta_ff <= RXD_IN;
         rx_sync_ff <= rx_meta_ff;
         wr_ff <= ap_act && HWRITE_IN;
         wa_ff <= ap_addr;
         rdata_ff <= nxt_rdata;
         rdy_ff <= 1'b1;
         resp_ff <= 1'b0;
      end
   end
   assign HRDATA_OUT = rdata_ff;
   assign HREADYOUT_OUT = rdy_ff;
   assign HRESP_OUT = resp_ff;

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   logic [1:0] ien_ff, nxt_ien;
   logic [4:0] lctl_ff, nxt_lctl;
   logic [15:0] div_ff, nxt_div;
   logic [8:0] fctl_ff, nxt_fctl;
   logic [7:0] scr_ff, nxt_scr;
   logic fifo_en;
   assign fifo_en = fctl_ff[FC_EN];
   always_comb begin
      nxt_ien = w_ien ? HWDATA_IN[1:0] : ien_ff;
      nxt_lctl = w_lctl ? HWDATA_IN[4:0] : lctl_ff;
      nxt_div = w_div ? HWDATA_IN[15:0] : div_ff;
      nxt_fctl = w_fctl ? HWDATA_IN[8:0] : fctl_ff;
      nxt_scr = w_scr ? HWDATA_IN[7:0] : scr_ff; // RQ6
   end
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         ien_ff <= '0;
         lctl_ff <= LCTL_RST;
         div_ff <= DIV_RST;
         fctl_ff <= '0;
         scr_ff <= '0;
      end else begin
         ien_ff <= nxt_ien;
         lctl_ff <= nxt_lctl;
         div_ff <= nxt_div;
         fctl_ff <= nxt_fctl;
         scr_ff <= nxt_scr;
      end
   end

   // ------------------------------------------------------------
   // baud generator, one tick per sixteenth of a bit
   // ------------------------------------------------------------
   logic [15:0] cnt_ff, nxt_cnt;
   logic tick_ff, nxt_tick;
   always_comb begin
      nxt_tick = 1'b0;
      nxt_cnt = cnt_ff - DIV_ONE;
      if (w_div) begin
         nxt_cnt = HWDATA_IN[15:0]; // RQ14
      end else if (cnt_ff <= DIV_ONE) begin
         nxt_cnt = div_ff; // RQ10 RQ12
         nxt_tick = div_ff != '0; // RQ13
      end
   end
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         cnt_ff <= DIV_RST;
         tick_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         tick_ff <= nxt_tick;
      end
   end

   // ------------------------------------------------------------
   // fifos
   // ------------------------------------------------------------
   logic [7:0] rx_mem [DEPTH];
   logic [7:0] tx_mem [DEPTH];
   logic [AW-1:0] rx_wp_ff, rx_rp_ff, tx_wp_ff, tx_rp_ff;
   logic [AW-1:0] nxt_rx_wp, nxt_rx_rp, nxt_tx_wp, nxt_tx_rp;
   logic [CW-1:0] rx_cnt_ff, tx_cnt_ff, nxt_rx_cnt, nxt_tx_cnt;
   logic rx_push, rx_wr, rx_rd, tx_wr, tx_pop;
   logic [7:0] rx_char;
   // overrun drops the new character, the store keeps its oldest ones
   assign rx_wr = rx_push && rx_cnt_ff < cap(fifo_en); // RQ1
   assign rx_rd = ap_rd && ap_addr == OFS_DATA && rx_cnt_ff != '0;
   assign tx_wr = w_data && tx_cnt_ff < cap(fifo_en); // RQ7
   always_comb begin
      nxt_rx_wp = rx_wp_ff + AW'(rx_wr);
      nxt_rx_rp = rx_rp_ff + AW'(rx_rd);
      nxt_rx_cnt = rx_cnt_ff + CW'(rx_wr) - CW'(rx_rd);
      nxt_tx_wp = tx_wp_ff + AW'(tx_wr);
      nxt_tx_rp = tx_rp_ff + AW'(tx_pop);
      nxt_tx_cnt = tx_cnt_ff + CW'(tx_wr) - CW'(tx_pop);
   end
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         rx_wp_ff <= '0;
         rx_rp_ff <= '0;
         rx_cnt_ff <= '0;
         tx_wp_ff <= '0;
         tx_rp_ff <= '0;
         tx_cnt_ff <= '0;
      end else begin
         rx_wp_ff <= nxt_rx_wp;
         rx_rp_ff <= nxt_rx_rp;
         rx_cnt_ff <= nxt_rx_cnt;
         tx_wp_ff <= nxt_tx_wp;
         tx_rp_ff <= nxt_tx_rp;
         tx_cnt_ff <= nxt_tx_cnt;
      end
   end
   always_ff @(posedge CLK_IN) begin
      if (rx_wr) begin
         rx_mem[rx_wp_ff] <= rx_char;
      end
      if (tx_wr) begin
         tx_mem[tx_wp_ff] <= HWDATA_IN[7:0];
      end
   end

   // ------------------------------------------------------------
   // receive shifter
   // ------------------------------------------------------------
   ubd_ser_t rx_st_ff, nxt_rx_st;
   logic [3:0] rx_tk_ff, nxt_rx_tk;
   logic [2:0] rx_bit_ff, nxt_rx_bit;
   logic [7:0] rx_sh_ff, nxt_rx_sh;
   assign rx_char = rx_sh_ff >> pad(lctl_ff);
   always_comb begin
      nxt_rx_st = rx_st_ff;
      nxt_rx_tk = tick_ff ? rx_tk_ff + 4'h1 : rx_tk_ff;
      nxt_rx_bit = rx_bit_ff;
      nxt_rx_sh = rx_sh_ff;
      rx_push = 1'b0;
      case (rx_st_ff)
         S_IDLE: begin
            nxt_rx_tk = '0;
            if (!rx_sync_ff) begin
               nxt_rx_st = S_START;
            end
         end
         S_START: begin
            if (tick_ff && rx_tk_ff == TK_MID) begin
               nxt_rx_tk = '0;
               nxt_rx_bit = '0;
               // a glitch shorter than half a bit is a false start
               nxt_rx_st = rx_sync_ff ? S_IDLE : S_DATA; // RQ15
            end
         end
         S_DATA: begin
            if (tick_ff && rx_tk_ff == TK_END) begin
               nxt_rx_sh = {rx_sync_ff, rx_sh_ff[7:1]}; // RQ2
               nxt_rx_bit = rx_bit_ff + 3'h1;
               if (rx_bit_ff == last_bit(lctl_ff)) begin
                  nxt_rx_st = lctl_ff[LC_PEN] ? S_PAR : S_STOP; // RQ11
               end
            end
         end
         S_PAR: begin
            if (tick_ff && rx_tk_ff == TK_END) begin
               nxt_rx_st = S_STOP;
            end
         end
         S_STOP: begin
            if (tick_ff && rx_tk_ff == TK_END) begin
               rx_push = 1'b1; // RQ2
               nxt_rx_st = S_IDLE;
            end
         end
         default: nxt_rx_st = S_IDLE;
      endcase
   end
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         rx_st_ff <= S_IDLE;
         rx_tk_ff <= '0;
         rx_bit_ff <= '0;
         rx_sh_ff <= '0;
      end else begin
         rx_st_ff <= nxt_rx_st;
         rx_tk_ff <= nxt_rx_tk;
         rx_bit_ff <= nxt_rx_bit;
         rx_sh_ff <= nxt_rx_sh;
      end
   end

   // ------------------------------------------------------------
   // transmit shifter
   // ------------------------------------------------------------
   ubd_ser_t tx_st_ff, nxt_tx_st;
   logic [3:0] tx_tk_ff, nxt_tx_tk;
   logic [2:0] tx_bit_ff, nxt_tx_bit;
   logic [7:0] tx_sh_ff, nxt_tx_sh, tx_head;
   logic tx_par_ff, nxt_tx_par, txd_ff, nxt_txd;
   assign tx_head = tx_mem[tx_rp_ff] & (8'hff >> pad(lctl_ff));
   always_comb begin
      nxt_tx_st = tx_st_ff;
      nxt_tx_tk = tick_ff ? tx_tk_ff + 4'h1 : tx_tk_ff;
      nxt_tx_bit = tx_bit_ff;
      nxt_tx_sh = tx_sh_ff;
      nxt_tx_par = tx_par_ff;
      tx_pop = 1'b0;
      case (tx_st_ff)
         S_IDLE: begin
            nxt_tx_tk = '0;
            if (tx_cnt_ff != '0) begin
               tx_pop = 1'b1; // RQ8
               nxt_tx_sh = tx_head;
               nxt_tx_par = ^tx_head ^ !lctl_ff[LC_EVEN]; // RQ11
               nxt_tx_st = S_START;
            end
         end
         S_START: begin
            if (tick_ff && tx_tk_ff == TK_END) begin
               nxt_tx_bit = '0;
               nxt_tx_st = S_DATA;
            end
         end
         S_DATA: begin
            if (tick_ff && tx_tk_ff == TK_END) begin
               nxt_tx_sh = tx_sh_ff >> 1;
               nxt_tx_bit = tx_bit_ff + 3'h1;
               if (tx_bit_ff == last_bit(lctl_ff)) begin
                  nxt_tx_bit = '0;
                  nxt_tx_st = lctl_ff[LC_PEN] ? S_PAR : S_STOP;
               end
            end
         end
         S_PAR: begin
            if (tick_ff && tx_tk_ff == TK_END) begin
               nxt_tx_st = S_STOP;
            end
         end
         S_STOP: begin
            if (tick_ff && tx_tk_ff == TK_END) begin
               nxt_tx_bit = 3'h1;
               if (!lctl_ff[LC_STOP2] || tx_bit_ff != '0) begin
                  nxt_tx_st = S_IDLE;
               end
            end
         end
         default: nxt_tx_st = S_IDLE;
      endcase
      case (tx_st_ff)
         S_START: nxt_txd = 1'b0; // RQ15
         S_DATA: nxt_txd = tx_sh_ff[0];
         S_PAR: nxt_txd = tx_par_ff;
         default: nxt_txd = 1'b1;
      endcase
   end
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         tx_st_ff <= S_IDLE;
         tx_tk_ff <= '0;
         tx_bit_ff <= '0;
         tx_sh_ff <= '0;
         tx_par_ff <= 1'b0;
         txd_ff <= 1'b1;
      end else begin
         tx_st_ff <= nxt_tx_st;
         tx_tk_ff <= nxt_tx_tk;
         tx_bit_ff <= nxt_tx_bit;
         tx_sh_ff <= nxt_tx_sh;
         tx_par_ff <= nxt_tx_par;
         txd_ff <= nxt_txd;
      end
   end
   assign TXD_OUT = txd_ff;

   // ------------------------------------------------------------
   // interrupt status, read data
   // ------------------------------------------------------------
   logic [1:0] ist_ff, nxt_ist, ev, clr;
   logic irq_ff, nxt_irq;
   always_comb begin
      if (fifo_en) begin
         ev[IRQ_RX] = fctl_ff[FC_RXT +: FC_TW] != '0 &&
            rx_cnt_ff >= CW'(fctl_ff[FC_RXT +: FC_TW]); // RQ5
         ev[IRQ_TX] = nxt_tx_cnt <= CW'(fctl_ff[FC_TXT +: FC_TW]); // RQ5
      end else begin
         ev[IRQ_RX] = rx_wr; // RQ3
         ev[IRQ_TX] = nxt_tx_cnt == '0; // RQ9
      end
      clr = {2{ap_rd && ap_addr == OFS_ISTAT}};
      clr[IRQ_RX] = clr[IRQ_RX] || (!fifo_en && rx_rd); // RQ4
      clr[IRQ_TX] = clr[IRQ_TX] || (!fifo_en && w_data); // RQ9
      // a new event wins over a clear in the same cycle
      nxt_ist = ev | (ist_ff & ~clr);
      nxt_irq = |(nxt_ist & ien_ff);
      nxt_rdata = '0;
      if (ap_rd) begin
         case (ap_addr)
            OFS_DATA: nxt_rdata = rx_rd ? DW'(rx_mem[rx_rp_ff]) : '0; // RQ1
            OFS_IEN: nxt_rdata = DW'(ien_ff);
            OFS_LCTL: nxt_rdata = DW'(lctl_ff);
            OFS_DIV: nxt_rdata = DW'(div_ff);
            OFS_FCTL: nxt_rdata = DW'(fctl_ff);
            OFS_SCR: nxt_rdata = DW'(scr_ff); // RQ6
            OFS_ISTAT: nxt_rdata = DW'(ist_ff);
            OFS_STATE: nxt_rdata = DW'(rx_cnt_ff) | (DW'(tx_cnt_ff) << ST_TXC) |
               (DW'(tx_st_ff != S_IDLE) << ST_TXB) | (DW'(rx_st_ff != S_IDLE) << ST_RXB);
            default: nxt_rdata = '0;
         endcase
      end
   end
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         ist_ff <= '0;
         irq_ff <= 1'b0;
      end else begin
         ist_ff <= nxt_ist;
         irq_ff <= nxt_irq;
      end
   end
   assign IRQ_OUT = irq_ff;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!ARST_N_IN);
   sequence s_quiet2;
      !w_div [*2];
   endsequence
   sequence s_tx_load;
      tx_pop ##1 tx_st_ff == S_START;
   endsequence
   a_div_reload: assert property (w_div |=> cnt_ff == $past(HWDATA_IN[15:0])) // RQ14
      else $error("baud counter not reloaded");
   a_tick_rate: assert property ((tick_ff && div_ff == 16'h0002 && !w_div) // RQ13
      ##1 s_quiet2 |-> tick_ff && !$past(tick_ff))
      else $error("tick spacing differs from divisor");
   a_rx_store: assert property (rx_wr && !rx_rd |=> rx_cnt_ff == $past(rx_cnt_ff) + 1'b1) // RQ1
      else $error("received character not stored");
   a_tx_idle_load: assert property (tx_pop |-> tx_st_ff == S_IDLE and s_tx_load) // RQ8
      else $error("shifter loaded while busy");
   a_tx_frame: assert property (tx_st_ff == S_START |=> !TXD_OUT) // RQ15
      else $error("start bit not low");
   a_tx_stop_high: assert property (tx_st_ff == S_STOP |=> TXD_OUT) // RQ15
      else $error("stop bit not high");
   a_rx_irq_set: assert property (!fifo_en && rx_wr && ien_ff[IRQ_RX] |=> IRQ_OUT) // RQ3
      else $error("receive interrupt missing");
   a_rx_irq_clr: assert property (!fifo_en && rx_rd && !rx_wr |=> !ist_ff[IRQ_RX]) // RQ4
      else $error("receive interrupt not cleared");
   a_tx_irq_set: assert property (!fifo_en && ien_ff[IRQ_TX] && tx_cnt_ff == '0 && !tx_wr // RQ9
      |=> IRQ_OUT)
      else $error("transmit empty interrupt missing");
   a_tx_irq_clr: assert property (!fifo_en && tx_wr |=> !ist_ff[IRQ_TX]) // RQ9
      else $error("transmit interrupt not cleared");
   a_fifo_irq: assert property (fifo_en && ien_ff[IRQ_RX] && ev[IRQ_RX] |=> IRQ_OUT) // RQ5
      else $error("fifo threshold interrupt missing");
   a_scratch_back: assert property (w_scr ##1 !w_scr |=> // RQ6
      scr_ff == $past(HWDATA_IN[7:0], 2))
      else $error("scratch byte lost");
endmodule

// >>> dv/ubd_far_end.sv
// remote serial device model facing the channel's serial pins
`timescale 1ns/100ps
module ubd_far_end #(
   parameter int BIT_CLKS = 32
) (
   input wire logic clk_in,
   input wire logic line_in,
   output logic line_out
);
   logic [7:0] rx_q[$];
   // bit after the eighth: parity, stop or idle, depending on the frame
   logic tail_q[$];
   logic [7:0] shift;

   initial line_out = 1'b1;

   // ------------------------------------------------------------
   // sender: whole frames only, line idles high between them
   // ------------------------------------------------------------
   task automatic send_char(input logic [7:0] v);
      line_out <= 1'b0;
      repeat (BIT_CLKS) @(posedge clk_in);
      for (int i = 0; i < 8; i++) begin
         line_out <= v[i];
         repeat (BIT_CLKS) @(posedge clk_in);
      end
      line_out <= 1'b1;
      repeat (BIT_CLKS) @(posedge clk_in);
   endtask

   // ------------------------------------------------------------
   // receiver: samples mid-bit, always eight bits, stop not checked
   // ------------------------------------------------------------
   // short chars read idle-high into the upper bits, which the bench expects
   always begin
      @(negedge line_in);
      repeat (BIT_CLKS / 2) @(posedge clk_in);
      if (line_in === 1'b0) begin
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge clk_in);
            shift[i] = line_in;
         end
         repeat (BIT_CLKS) @(posedge clk_in);
         tail_q.push_back(line_in);
         rx_q.push_back(shift);
      end
   end
endmodule

// >>> dv/uart_buffer_datapath_test.sv
// bench: register and serial scenarios of one channel data path
`timescale 1ns/100ps
module uart_buffer_datapath_test;
   import ubd_pkg::*;
   // small divisor keeps frames short: one bit is 16 * div_val clocks
   localparam int DIV_VAL = 2;
   logic clk, arst_n, hsel, hwrite, hreadyout, hresp, rxd, txd, irq;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata;
   int fail_count, checks_done;

   ubd_top #(.DEPTH(16)) dut (
      .CLK_IN(clk),
      .ARST_N_IN(arst_n),
      .HSEL_IN(hsel),
      .HADDR_IN(haddr),
      .HTRANS_IN(htrans),
      .HWRITE_IN(hwrite),
      .HSIZE_IN(hsize),
      .HWDATA_IN(hwdata),
      .HREADY_IN(hreadyout),
      .HRDATA_OUT(hrdata),
      .HREADYOUT_OUT(hreadyout),
      .HRESP_OUT(hresp),
      .RXD_IN(rxd),
      .TXD_OUT(txd),
      .IRQ_OUT(irq)
   );

   ubd_far_end #(.BIT_CLKS(16 * DIV_VAL)) far (
      .clk_in(clk),
      .line_in(txd),
      .line_out(rxd)
   );

   always #5 clk = ~clk;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] ra(input logic [7:0] ofs);
      return {24'h0, ofs};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wait_rdy;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
   endtask

   task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
      haddr <= a;
      hwrite <= 1'b1;
      htrans <= 2'h2;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
   endtask

   task automatic bus_rd(input logic [31:0] a, output logic [31:0] d);
      haddr <= a;
      hwrite <= 1'b0;
      htrans <= 2'h2;
      wait_rdy();
      htrans <= 2'h0;
      wait_rdy();
      d = hrdata;
      check({31'h0, hresp}, 32'h0);
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] d;
      bus_rd(a, d);
      check(d, exp);
   endtask

   task automatic irq_chk(input logic e);
      check({31'h0, irq}, {31'h0, e});
   endtask

   // bounded wait for the far end to collect n characters
   task automatic wait_far(input int n);
      for (int k = 0; k < 8000 && far.rx_q.size() < n; k++) @(posedge clk);
   endtask

   task automatic end_of_test;
      $display("checks_done %0d fail_count %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // watchdog
   // ------------------------------------------------------------
   initial begin
      repeat (40000) @(posedge clk);
      fail_count++;
      end_of_test();
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      arst_n = 1'b0;
      hsel = 1'b1;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      fail_count = 0;
      checks_done = 0;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      rd_chk(ra(OFS_IEN), 32'h0);
      rd_chk(ra(OFS_LCTL), 32'h3);
      rd_chk(ra(OFS_DIV), 32'h14);
      rd_chk(ra(OFS_FCTL), 32'h0);
      rd_chk(ra(OFS_SCR), 32'h0);
      rd_chk(32'h100, 32'h0);
      // scratch keeps only its byte and disturbs nothing else
      bus_wr(ra(OFS_SCR), 32'h123456a5);
      bus_wr(32'h100, 32'hff);
      rd_chk(ra(OFS_SCR), 32'ha5);
      rd_chk(ra(OFS_LCTL), 32'h3);
      irq_chk(1'b0);
      bus_wr(ra(OFS_DIV), 32'(DIV_VAL));
      rd_chk(ra(OFS_DIV), 32'(DIV_VAL));
      // compatibility mode transmit: empty holding interrupts, a load clears it
      bus_wr(ra(OFS_IEN), 32'h2);
      tick(2);
      irq_chk(1'b1);
      bus_wr(ra(OFS_DATA), 32'h5a);
      bus_wr(ra(OFS_DATA), 32'h3c1);
      tick(3);
      irq_chk(1'b0);
      wait_far(2);
      check({24'h0, far.rx_q.pop_front()}, 32'h5a);
      check({24'h0, far.rx_q.pop_front()}, 32'hc1);
      irq_chk(1'b1);
      // five-bit characters end early, so idle-high fills the upper bits
      bus_wr(ra(OFS_LCTL), 32'h0);
      bus_wr(ra(OFS_DATA), 32'h05);
      wait_far(1);
      check({24'h0, far.rx_q.pop_front()}, 32'he5);
      // even parity: the far end sees the parity bit right after the eighth data bit
      far.tail_q.delete();
      bus_wr(ra(OFS_LCTL), 32'h1b);
      bus_wr(ra(OFS_DATA), 32'h5a);
      bus_wr(ra(OFS_DATA), 32'h5b);
      wait_far(2);
      check({24'h0, far.rx_q.pop_front()}, 32'h5a);
      check({24'h0, far.rx_q.pop_front()}, 32'h5b);
      check({31'h0, far.tail_q.pop_front()}, 32'h0);
      check({31'h0, far.tail_q.pop_front()}, 32'h1);
      bus_wr(ra(OFS_LCTL), 32'h3);
      // compatibility mode receive: masked, then raised, cleared by the read
      bus_wr(ra(OFS_IEN), 32'h0);
      far.send_char(8'h96);
      tick(4);
      irq_chk(1'b0);
      bus_wr(ra(OFS_IEN), 32'h1);
      tick(2);
      irq_chk(1'b1);
      rd_chk(ra(OFS_DATA), 32'h96);
      tick(2);
      irq_chk(1'b0);
      // enabled before arrival: the store itself raises the interrupt
      far.send_char(8'h69);
      tick(4);
      irq_chk(1'b1);
      rd_chk(ra(OFS_DATA), 32'h69);
      // fifo mode receive, threshold three
      bus_wr(ra(OFS_FCTL), 32'h7);
      far.send_char(8'h11);
      far.send_char(8'h22);
      tick(4);
      irq_chk(1'b0);
      far.send_char(8'h33);
      tick(4);
      irq_chk(1'b1);
      rd_chk(ra(OFS_STATE), 32'h3);
      for (int i = 0; i < 3; i++) begin
         rd_chk(ra(OFS_DATA), 32'(17 * (i + 1)));
      end
      rd_chk(ra(OFS_ISTAT), 32'h3);
      tick(2);
      irq_chk(1'b0);
      // fifo mode transmit: queue four back to back, shifter takes one
      for (int i = 0; i < 4; i++) begin
         bus_wr(ra(OFS_DATA), 32'(64 + i));
      end
      tick(5);
      rd_chk(ra(OFS_STATE), 32'h10300);
      wait_far(4);
      for (int i = 0; i < 4; i++) begin
         check({24'h0, far.rx_q.pop_front()}, 32'(64 + i));
         check({31'h0, far.tail_q.pop_front()}, 32'h1);
      end
      end_of_test();
   end
endmodule
